// ===== logic/hdm_defs.svh
// Constants of the harmonic distortion monitor
`ifndef HDM_DEFS_SVH
`define HDM_DEFS_SVH
`define HDM_CLK_PERIOD_NS 10
`define HDM_TICK_TIME_US 5000
`define HDM_NUM_CH 5
`define HDM_NUM_REC 12
`define HDM_NUM_EV 7
`define HDM_ADDR_CTRL 6'h00
`define HDM_ADDR_LIM_PH 6'h01
`define HDM_ADDR_LIM_R1 6'h02
`define HDM_ADDR_LIM_R2 6'h03
`define HDM_ADDR_DLY_PH 6'h04
`define HDM_ADDR_DLY_R1 6'h05
`define HDM_ADDR_DLY_R2 6'h06
`define HDM_ADDR_STATUS 6'h07
`define HDM_ADDR_DIST0 6'h08
`define HDM_ADDR_CNT0 6'h10
`define HDM_ADDR_REC_SEL 6'h18
`define HDM_ADDR_REC_TIME 6'h19
`define HDM_ADDR_REC_INFO 6'h1a
`define HDM_ADDR_REC_DIST0 6'h1b
`define HDM_ADDR_REC_COUNT 6'h1e
`define HDM_CTRL_METHOD_BIT 0
`define HDM_CTRL_EN_LSB 1
`define HDM_CTRL_CLR_BIT 8
`define HDM_CTRL_RESET 4'he
`define HDM_LIMIT_DEFAULT 14'h03e8
`define HDM_DELAY_DEFAULT 19'h007d0
`define HDM_DC_BIN 5'h00
`define HDM_FUND_BIN 5'h01
`define HDM_LAST_BIN 5'h1f
`define HDM_Q_SCALE 27'h5f5e100
`define HDM_PWR_SCALE 14'h2710
`define HDM_PCT 7'h64
`define HDM_REL_PCT 7'h61
`define HDM_AMP_REL 14'h24c1
`define HDM_Q_SAT 32'hffffffff
`endif

// ===== logic/hdm_pkg.sv
// Types of the harmonic distortion monitor
package hdm_pkg;
  typedef enum logic [0:0] {
    HDM_DIV_IDLE = 1'b0,
    HDM_DIV_RUN = 1'b1
  } hdm_div_state_type;
  typedef logic [31:0] hdm_word_type;
endpackage

// ===== logic/hdm_monitor.sv
// Harmonic distortion monitor: spectrum accumulation, ratio, pick-up, timing, events, records
//
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`include "hdm_defs.svh"

module hdm_monitor
  import hdm_pkg::*;
#(
  parameter int TICK_CYCLES = `HDM_TICK_TIME_US * 1000 / `HDM_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // Spectrum stream
  input wire logic i_bin_valid,
  input wire logic [2:0] i_bin_chan,
  input wire logic [4:0] i_bin_index,
  input wire logic [15:0] i_bin_mag,
  output logic o_bin_ready,
  // Blocking and setting group
  input wire logic i_block,
  input wire logic [2:0] i_setting_group,
  // Register port
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Indications
  output logic [2:0] o_start,
  output logic [2:0] o_alarm,
  output logic o_blocked,
  output logic [6:0] o_event_on,
  output logic [6:0] o_event_off
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  logic [3:0] ctrl_reg;
  logic [13:0] limit_reg [3];
  logic [18:0] delay_reg [3];
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  logic [31:0] time_reg;
  logic [31:0] fund_reg;
  logic [36:0] sum_reg;
  logic [31:0] sq;
  logic take;
  hdm_div_state_type div_state_reg;
  logic [4:0] div_cnt_reg;
  logic [2:0] div_chan_reg;
  logic [31:0] div_d_reg;
  logic [31:0] div_rem_reg;
  logic [31:0] div_low_reg;
  logic div_sat_reg;
  logic div_zero_reg;
  logic [63:0] num;
  logic [32:0] trial;
  logic div_done;
  logic [31:0] q;
  logic [31:0] dist_reg [`HDM_NUM_CH];
  logic [`HDM_NUM_CH-1:0] over_reg;
  logic [1:0] grp;
  logic [13:0] lim;
  logic [27:0] lim_pwr;
  logic [34:0] lim_rel;
  logic [38:0] q_pct;
  logic [27:0] lim_sq;
  logic [45:0] q_amp;
  logic [41:0] amp_rel;
  logic pick;
  logic release_ok;
  logic [2:0] pickup;
  logic [2:0] start_reg;
  logic [2:0] alarm_reg;
  logic blocked_reg;
  logic [18:0] timer_reg [3];
  logic [6:0] st;
  logic [6:0] st_prev_reg;
  logic clear;
  logic [15:0] cnt_reg [`HDM_NUM_EV];
  logic [31:0] rec_time [`HDM_NUM_REC];
  logic [5:0] rec_info [`HDM_NUM_REC];
  logic [31:0] rec_dist [`HDM_NUM_REC][3];
  logic [3:0] rec_wp_reg;
  logic [3:0] rec_cnt_reg;
  logic [3:0] rec_sel_reg;
  logic [2:0] ev_code;
  logic [4:0] rd_sum;
  logic [3:0] rd_idx;
  logic [31:0] rdata;

  // Settings; method and enables in ctrl, one limit and delay per element, not switched by the setting group
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl_reg <= `HDM_CTRL_RESET;
      rec_sel_reg <= 4'h0;
      for (int g = 0; g < 3; g++) begin
        limit_reg[g] <= `HDM_LIMIT_DEFAULT;
        delay_reg[g] <= `HDM_DELAY_DEFAULT;
      end
    end else if (i_wr) begin
      if (i_addr == `HDM_ADDR_CTRL) ctrl_reg <= i_wdata[3:0];
      if (i_addr == `HDM_ADDR_LIM_PH) limit_reg[0] <= i_wdata[13:0];
      if (i_addr == `HDM_ADDR_LIM_R1) limit_reg[1] <= i_wdata[13:0];
      if (i_addr == `HDM_ADDR_LIM_R2) limit_reg[2] <= i_wdata[13:0];
      if (i_addr == `HDM_ADDR_DLY_PH) delay_reg[0] <= i_wdata[18:0];
      if (i_addr == `HDM_ADDR_DLY_R1) delay_reg[1] <= i_wdata[18:0];
      if (i_addr == `HDM_ADDR_DLY_R2) delay_reg[2] <= i_wdata[18:0];
      if (i_addr == `HDM_ADDR_REC_SEL) rec_sel_reg <= i_wdata[3:0];
    end
  end
  assign clear = i_wr && (i_addr == `HDM_ADDR_CTRL) && i_wdata[`HDM_CTRL_CLR_BIT];

  assign tick = (tick_cnt_reg == TW'(TICK_CYCLES - 1));
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_cnt_reg <= '0;
      time_reg <= 32'h0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
      time_reg <= time_reg + 32'h1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + TW'(1);
    end
  end

  // accumulate one spectrum per channel; DC bin clears the sum and adds nothing
  assign take = i_bin_valid && o_bin_ready;
  assign sq = i_bin_mag * i_bin_mag;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fund_reg <= 32'h0;
      sum_reg <= 37'h0;
    end else if (take) begin
      if (i_bin_index == `HDM_DC_BIN) sum_reg <= 37'h0;
      else if (i_bin_index == `HDM_FUND_BIN) fund_reg <= sq;
      else sum_reg <= sum_reg + 37'(sq);
    end
  end

  // Restoring divider: ratio in 1e-8 units; saturates instead of wrapping
  assign num = (sum_reg + 37'(sq)) * `HDM_Q_SCALE;
  assign trial = {div_rem_reg, div_low_reg[31]};
  assign div_done = (div_state_reg == HDM_DIV_RUN) && (div_cnt_reg == `HDM_LAST_BIN);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_state_reg <= HDM_DIV_IDLE;
      div_cnt_reg <= 5'h0;
      div_chan_reg <= 3'h0;
      div_d_reg <= 32'h0;
      div_rem_reg <= 32'h0;
      div_low_reg <= 32'h0;
      div_sat_reg <= 1'b0;
      div_zero_reg <= 1'b0;
    end else begin
      unique case (div_state_reg)
        HDM_DIV_IDLE: begin
          if (take && i_bin_index == `HDM_LAST_BIN) begin
            div_state_reg <= HDM_DIV_RUN;
            div_cnt_reg <= 5'h0;
            div_chan_reg <= i_bin_chan;
            div_d_reg <= fund_reg;
            div_zero_reg <= (fund_reg == 32'h0);
            div_sat_reg <= (num[63:32] >= fund_reg);
            div_rem_reg <= (num[63:32] >= fund_reg) ? 32'h0 : num[63:32];
            div_low_reg <= num[31:0];
          end
        end
        HDM_DIV_RUN: begin
          div_cnt_reg <= div_cnt_reg + 5'h1;
          if (trial >= {1'b0, div_d_reg}) begin
            div_rem_reg <= 32'(trial - {1'b0, div_d_reg});
            div_low_reg <= {div_low_reg[30:0], 1'b1};
          end else begin
            div_rem_reg <= trial[31:0];
            div_low_reg <= {div_low_reg[30:0], 1'b0};
          end
          if (div_done) div_state_reg <= HDM_DIV_IDLE;
        end
      endcase
    end
  end
  // Front end stalls while the divider owns the spectrum totals
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) o_bin_ready <= 1'b1;
    else if (take && i_bin_index == `HDM_LAST_BIN) o_bin_ready <= 1'b0;
    else if (div_done) o_bin_ready <= 1'b1;
  end
  assign q = div_zero_reg ? 32'h0 : div_sat_reg ? `HDM_Q_SAT : {div_low_reg[30:0],
             (trial >= {1'b0, div_d_reg})};

  // Comparison against the limit of the channel's element
  assign grp = (div_chan_reg < 3'h3) ? 2'h0 : (div_chan_reg == 3'h3) ? 2'h1 : 2'h2;
  assign lim = limit_reg[grp];
  assign lim_pwr = lim * `HDM_PWR_SCALE;
  assign lim_rel = lim_pwr * `HDM_REL_PCT;
  assign q_pct = q * `HDM_PCT;
  assign lim_sq = lim * lim;
  assign q_amp = q * `HDM_PWR_SCALE;
  assign amp_rel = lim_sq * `HDM_AMP_REL;
  // power compares directly, amplitude compares squared
  assign pick = ctrl_reg[`HDM_CTRL_METHOD_BIT] ? (q > 32'(lim_pwr)) : (q > 32'(lim_sq));
  // release below 97 percent of setting
  assign release_ok = ctrl_reg[`HDM_CTRL_METHOD_BIT] ? (q_pct < 39'(lim_rel)) :
                      (q_amp < 46'(amp_rel));

  // figures change only when a spectrum is finished; over flags also clear while the element is disabled
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      over_reg <= '0;
      for (int c = 0; c < `HDM_NUM_CH; c++) dist_reg[c] <= 32'h0;
    end else begin
      for (int c = 0; c < `HDM_NUM_CH; c++) begin
        if (!ctrl_reg[`HDM_CTRL_EN_LSB + ((c < 3) ? 0 : c - 2)]) over_reg[c] <= 1'b0;
        else if (div_done && div_chan_reg == 3'(c)) begin
          dist_reg[c] <= q;
          if (pick) over_reg[c] <= 1'b1;
          else if (release_ok) over_reg[c] <= 1'b0;
        end
      end
    end
  end
  // any phase; residual inputs on their own
  assign pickup = {over_reg[4], over_reg[3], |over_reg[2:0]};

  // Start and definite-time alarm per element; one block input and blocked flag common to all
  generate
    for (genvar g = 0; g < 3; g++) begin : gen_elem
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          start_reg[g] <= 1'b0;
          alarm_reg[g] <= 1'b0;
          timer_reg[g] <= 19'h0;
        end else begin
          // block turns pick-up away from start
          start_reg[g] <= pickup[g] && !i_block;
          if (!(pickup[g] && !i_block) || !start_reg[g]) timer_reg[g] <= 19'h0;
          else if (tick && timer_reg[g] < delay_reg[g]) timer_reg[g] <= timer_reg[g] + 19'h1;
          // alarm after start has lasted the delay
          alarm_reg[g] <= start_reg[g] && pickup[g] && !i_block && (timer_reg[g] >= delay_reg[g]);
        end
      end
    end
  endgenerate
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) blocked_reg <= 1'b0;
    // blocked shown while any enabled pick-up meets the block input
    else blocked_reg <= (|pickup) && i_block;
  end

  // on and off events from edges
  assign st = {blocked_reg, alarm_reg, start_reg};
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_prev_reg <= 7'h0;
      o_event_on <= 7'h0;
      o_event_off <= 7'h0;
      o_start <= 3'h0;
      o_alarm <= 3'h0;
      o_blocked <= 1'b0;
    end else begin
      st_prev_reg <= st;
      o_event_on <= st & ~st_prev_reg;
      o_event_off <= ~st & st_prev_reg;
      o_start <= start_reg;
      o_alarm <= alarm_reg;
      o_blocked <= blocked_reg;
    end
  end
  // counters; an event in the clearing cycle still counts
  generate
    for (genvar e = 0; e < `HDM_NUM_EV; e++) begin : gen_cnt
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) cnt_reg[e] <= 16'h0;
        else if (o_event_on[e]) cnt_reg[e] <= clear ? 16'h1 : cnt_reg[e] + 16'h1;
        else if (clear) cnt_reg[e] <= 16'h0;
      end
    end
  endgenerate

  // record ring; lowest on event wins when several coincide
  always_comb begin
    ev_code = 3'h0;
    for (int e = `HDM_NUM_EV - 1; e >= 0; e--) begin
      if (o_event_on[e]) ev_code = 3'(e);
    end
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rec_wp_reg <= 4'h0;
      rec_cnt_reg <= 4'h0;
    end else if (|o_event_on) begin
      rec_wp_reg <= (rec_wp_reg == 4'(`HDM_NUM_REC - 1)) ? 4'h0 : rec_wp_reg + 4'h1;
      if (rec_cnt_reg != 4'(`HDM_NUM_REC)) rec_cnt_reg <= rec_cnt_reg + 4'h1;
    end
  end
  // Record store has no reset; only entries below the count are meaningful
  always_ff @(posedge i_clk) begin
    if (|o_event_on) begin
      rec_time[rec_wp_reg] <= time_reg;
      rec_info[rec_wp_reg] <= {i_setting_group, ev_code};
      for (int p = 0; p < 3; p++) rec_dist[rec_wp_reg][p] <= dist_reg[p];
    end
  end

  // Register read: data in the cycle after the strobe, unmapped reads zero
  assign rd_sum = 5'(rec_wp_reg) + 5'(`HDM_NUM_REC - 1) - 5'(rec_sel_reg);
  assign rd_idx = (rd_sum >= 5'(`HDM_NUM_REC)) ? 4'(rd_sum - 5'(`HDM_NUM_REC)) : rd_sum[3:0];
  always_comb begin
    rdata = 32'h0;
    if (i_addr == `HDM_ADDR_CTRL) rdata = {28'h0, ctrl_reg};
    else if (i_addr >= `HDM_ADDR_LIM_PH && i_addr <= `HDM_ADDR_LIM_R2)
      rdata = {18'h0, limit_reg[2'(i_addr - `HDM_ADDR_LIM_PH)]};
    else if (i_addr >= `HDM_ADDR_DLY_PH && i_addr <= `HDM_ADDR_DLY_R2)
      rdata = {13'h0, delay_reg[2'(i_addr - `HDM_ADDR_DLY_PH)]};
    else if (i_addr == `HDM_ADDR_STATUS) rdata = {25'h0, st};
    else if (i_addr >= `HDM_ADDR_DIST0 && i_addr < `HDM_ADDR_DIST0 + 6'(`HDM_NUM_CH))
      rdata = dist_reg[3'(i_addr - `HDM_ADDR_DIST0)];
    else if (i_addr >= `HDM_ADDR_CNT0 && i_addr < `HDM_ADDR_CNT0 + 6'(`HDM_NUM_EV))
      rdata = {16'h0, cnt_reg[3'(i_addr - `HDM_ADDR_CNT0)]};
    else if (i_addr == `HDM_ADDR_REC_SEL) rdata = {28'h0, rec_sel_reg};
    else if (i_addr == `HDM_ADDR_REC_TIME) rdata = rec_time[rd_idx];
    else if (i_addr == `HDM_ADDR_REC_INFO) rdata = {26'h0, rec_info[rd_idx]};
    else if (i_addr >= `HDM_ADDR_REC_DIST0 && i_addr < `HDM_ADDR_REC_COUNT)
      rdata = rec_dist[rd_idx][2'(i_addr - `HDM_ADDR_REC_DIST0)];
    else if (i_addr == `HDM_ADDR_REC_COUNT) rdata = {28'h0, rec_cnt_reg};
  end
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) o_rdata <= 32'h0;
    else if (i_rd) o_rdata <= rdata;
    else o_rdata <= 32'h0;
  end
endmodule

// ===== tb/hdm_monitor_asserts.sv
// Port checks for the harmonic distortion monitor
`timescale 1ns/100ps
module hdm_monitor_asserts #(
  parameter int TICK_CYCLES = 10
) (
  // Clock, reset, stream
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_bin_valid,
  input wire logic [4:0] i_bin_index,
  input wire logic o_bin_ready,
  // Block and registers
  input wire logic i_block,
  input wire logic [5:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Indications
  input wire logic [2:0] o_start,
  input wire logic [2:0] o_alarm,
  input wire logic o_blocked,
  input wire logic [6:0] o_event_on,
  input wire logic [6:0] o_event_off
);
  logic [6:0] stat_now;
  logic [6:0] stat_reg;
  logic [6:0] rise_now;
  logic [6:0] fall_now;
  logic [2:0] en_reg;
  assign stat_now = {o_blocked, o_alarm, o_start};
  assign rise_now = stat_now & ~stat_reg;
  assign fall_now = stat_reg & ~stat_now;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      stat_reg <= 7'h00;
    end else begin
      stat_reg <= stat_now;
    end
  end
  // Own copy of the enables, so a broken write decode is seen
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_reg <= 3'h7;
    end else if (i_wr && i_addr == 6'h00) begin
      en_reg <= i_wdata[3:1];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not idle");
  a_ready_drop: assert property (
    (i_bin_valid && o_bin_ready && i_bin_index == 5'h1f) |=> !o_bin_ready)
    else $error("ready high after last bin");
  a_ready_gap: assert property (
    $fell(o_bin_ready) |-> ##31 !o_bin_ready ##1 o_bin_ready)
    else $error("ready gap wrong");
  a_block_start: assert property (
    (i_block) [*4] |-> o_start == 3'h0)
    else $error("start while blocked");
  a_block_flag: assert property (
    (!i_block) [*4] |-> !o_blocked)
    else $error("blocked without block");
  a_alarm_start: assert property (
    (o_alarm & ~o_start & ~$past(o_start)) == 3'h0)
    else $error("alarm without start");
  a_event_on: assert property (o_event_on == rise_now)
    else $error("on event wrong");
  a_event_off: assert property (o_event_off == fall_now)
    else $error("off event wrong");
  a_disabled_quiet: assert property (
    ((o_start | o_alarm) & ~(en_reg | $past(en_reg) | $past(en_reg, 2) | $past(en_reg, 3)))
    == 3'h0)
    else $error("disabled element active");
endmodule

// ===== tb/hdm_fe_model.sv
// Front end stand-in streaming 32-bin spectra
`timescale 1ns/100ps
module hdm_fe_model (
  // Clock and flow control
  input wire logic i_clk,
  input wire logic i_ready,
  // Bin stream
  output logic o_valid,
  output logic [2:0] o_chan,
  output logic [4:0] o_index,
  output logic [15:0] o_mag
);
  logic rdy_seen;
  int stalls;
  // Taken mid-cycle so it equals what the block samples next edge
  always @(negedge i_clk) rdy_seen = i_ready;
  initial begin
    o_valid = 1'b0;
    o_chan = 3'h0;
    o_index = 5'h00;
    o_mag = 16'ha5a5;
    stalls = 0;
  end
  task automatic send(input logic [2:0] ch, input logic [15:0] f, input logic [15:0] h2,
                      input logic [15:0] h31, input bit slow);
    int i;
    int k;
    @(posedge i_clk);
    for (i = 0; i < 32; i++) begin
      if (slow) begin
        o_valid <= 1'b0;
        o_mag <= ~o_mag;
        @(posedge i_clk);
      end
      o_valid <= 1'b1;
      o_chan <= ch;
      o_index <= i[4:0];
      o_mag <= (i == 1) ? f : (i == 2) ? h2 : (i == 31) ? h31 : (i == 0) ? 16'h5a5a : 16'h0;
      k = 0;
      @(posedge i_clk);
      while (!rdy_seen && k < 200) begin
        @(posedge i_clk);
        k++;
      end
      if (k == 200) begin
        stalls++;
      end
    end
    o_valid <= 1'b0;
    o_mag <= ~o_mag;
  endtask
endmodule

// ===== tb/hdm_monitor_tb_top.sv
// Self-checking bench for the harmonic distortion monitor
`timescale 1ns/100ps
module hdm_monitor_tb_top;
  logic clk;
  logic rst_n;
  logic bin_valid;
  logic [2:0] bin_chan;
  logic [4:0] bin_index;
  logic [15:0] bin_mag;
  logic bin_ready;
  logic blk;
  logic [2:0] grp;
  logic [5:0] addr;
  logic [31:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [31:0] rdata;
  logic [2:0] start;
  logic [2:0] alarm;
  logic blocked;
  int err_total;
  int n_tests;
  int c;
  hdm_monitor #(.TICK_CYCLES(10)) dut (.i_clk(clk), .i_reset_n(rst_n),
    .i_bin_valid(bin_valid), .i_bin_chan(bin_chan), .i_bin_index(bin_index),
    .i_bin_mag(bin_mag), .o_bin_ready(bin_ready), .i_block(blk), .i_setting_group(grp),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_start(start), .o_alarm(alarm), .o_blocked(blocked), .o_event_on(), .o_event_off());
  hdm_fe_model fe (.i_clk(clk), .i_ready(bin_ready), .o_valid(bin_valid),
    .o_chan(bin_chan), .o_index(bin_index), .o_mag(bin_mag));
  always #5 clk = ~clk;
  task automatic tally_and_finish;
    $display("Counts: tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic st(input logic [2:0] e);
    chk("start", {29'h0, e}, {29'h0, start});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  task automatic spec(input logic [2:0] ch, input logic [15:0] h2, input logic [15:0] h31,
                      input bit slow);
    fe.send(ch, 16'h03e8, h2, h31, slow);
    if (fe.stalls != 0) begin
      err_total++;
      tally_and_finish;
    end
    wt(40);
  endtask
  initial begin
    repeat (50000) @(posedge clk);
    err_total++;
    tally_and_finish;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    blk = 1'b0;
    grp = 3'h5;
    addr = 6'h00;
    wdata = 32'h0;
    wr_s = 1'b0;
    rd_s = 1'b0;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(6'h00, 32'he, "ctrl");
    for (c = 1; c < 4; c++) begin
      rd(c[5:0], 32'h3e8, "limit");
    end
    rd(6'h04, 32'h7d0, "delay");
    wr(6'h07, 32'h7f);
    rd(6'h07, 32'h0, "status");
    rd(6'h3f, 32'h0, "unmapped");
    // Any single phase, one being slow
    for (c = 0; c < 3; c++) begin
      spec(c[2:0], 16'h006e, 16'h0, c[0]);
      st(3'h1);
      spec(c[2:0], 16'h0032, 16'h0, 1'b0);
      st(3'h0);
    end
    spec(3'h3, 16'h006e, 16'h0, 1'b0);
    st(3'h2);
    spec(3'h3, 16'h0, 16'h0, 1'b0);
    spec(3'h4, 16'h006e, 16'h0, 1'b0);
    st(3'h4);
    spec(3'h4, 16'h0, 16'h0, 1'b0);
    st(3'h0);
    spec(3'h0, 16'h006e, 16'h0, 1'b0);
    spec(3'h0, 16'h0061, 16'h0, 1'b0);
    st(3'h1);
    spec(3'h0, 16'h0060, 16'h0, 1'b0);
    st(3'h0);
    wr(6'h04, 32'h3);
    wr(6'h01, 32'h44c);
    spec(3'h0, 16'h006e, 16'h0, 1'b0);
    st(3'h0);
    wr(6'h01, 32'h44b);
    spec(3'h0, 16'h006e, 16'h0, 1'b0);
    st(3'h1);
    chk("alarm", 32'h0, {29'h0, alarm});
    wt(50);
    chk("alarm", 32'h1, {29'h0, alarm});
    @(posedge clk);
    blk <= 1'b1;
    wt(6);
    st(3'h0);
    chk("blocked", 32'h1, {31'h0, blocked});
    @(posedge clk);
    blk <= 1'b0;
    wt(6);
    chk("blocked", 32'h0, {31'h0, blocked});
    st(3'h1);
    wr(6'h00, 32'hc);
    wt(5);
    st(3'h0);
    spec(3'h0, 16'h006e, 16'h0, 1'b0);
    st(3'h0);
    wr(6'h00, 32'he);
    spec(3'h0, 16'h006e, 16'h0, 1'b0);
    st(3'h1);
    spec(3'h0, 16'h0, 16'h0, 1'b0);
    // Clear counters and switch to power ratio
    wr(6'h00, 32'h10f);
    rd(6'h10, 32'h0, "count");
    wr(6'h01, 32'h64);
    spec(3'h0, 16'h003c, 16'h0050, 1'b0);
    st(3'h0);
    rd(6'h08, 32'hf4240, "distortion");
    wr(6'h01, 32'h63);
    spec(3'h0, 16'h003c, 16'h0050, 1'b0);
    st(3'h1);
    rd(6'h1a, 32'h28, "record event");
    rd(6'h1b, 32'hf4240, "record figure");
    rd(6'h1e, 32'hc, "records");
    rd(6'h10, 32'h1, "count");
    tally_and_finish;
  end
endmodule
bind hdm_monitor hdm_monitor_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.i_clk(i_clk),
  .i_reset_n(i_reset_n), .i_bin_valid(i_bin_valid), .i_bin_index(i_bin_index),
  .o_bin_ready(o_bin_ready), .i_block(i_block), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start), .o_alarm(o_alarm),
  .o_blocked(o_blocked), .o_event_on(o_event_on), .o_event_off(o_event_off));
